/* File: sim/gsw_encoder_checker.sv */
`timescale 1ns/1ns
// ----------------------------------------
// status word and response checks
// ----------------------------------------
module gsw_encoder_checker #(
    parameter NUM_SLOT = 48
) (
    input wire core_clk,
    input wire reset,
    input wire red_active,
    input wire [NUM_SLOT-1:0] sim_mask,
    input wire param_busy,
    input wire dx_start,
    input wire dx_byte_ready,
    input wire dx_byte_valid,
    input wire dx_byte_first,
    input wire [7:0] dx_byte,
    input wire dx_done,
    input wire dx_busy,
    input wire [15:0] status_word,
    input wire [6:0] fault_count
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    chk_active_bit: assert property (
        !$past(reset) |-> status_word[15] == $past(red_active))
        else $error("active bit wrong");
    chk_sim_bit: assert property (
        !$past(reset) |-> status_word[14] == |$past(sim_mask))
        else $error("simulation bit wrong");
    chk_param_bit: assert property (
        !$past(reset) |-> status_word[6] == $past(param_busy))
        else $error("param bit wrong");
    chk_fault_flag: assert property (
        status_word[13] == (fault_count != 7'h00))
        else $error("fault flag wrong");
    chk_module_flag: assert property (
        status_word[12] == (status_word[11:8] == 4'h6))
        else $error("module flag wrong");
    chk_clear_word: assert property (
        !status_word[13] |-> status_word[12:7] == 6'h00
        && status_word[5:0] == 6'h00) else $error("idle word wrong");
    chk_multi_count: assert property (
        status_word[7] |-> fault_count > 7'h01
        && status_word[5:0] == fault_count[5:0]) else $error("count wrong");
    chk_single_flag: assert property (
        fault_count == 7'h01 |-> !status_word[7])
        else $error("single fault flag");
    chk_high_first: assert property (
        dx_start && !dx_busy |=> dx_byte_valid && dx_byte_first
        && dx_byte == $past(status_word[15:8])) else $error("high byte");
    chk_low_second: assert property (
        dx_start && !dx_busy ##1 dx_byte_ready |=> dx_byte_valid
        && !dx_byte_first && dx_byte == $past(status_word[7:0], 2))
        else $error("low byte");
    chk_done_pulse: assert property (
        dx_byte_valid && !dx_byte_first && dx_byte_ready |=> dx_done
        && !dx_busy ##1 !dx_done) else $error("done pulse");
    cover property (status_word[7]);
    cover property (status_word[11:8] == 4'h7 && !status_word[7]);
    cover property (dx_done && dx_start);
endmodule
bind gsw_encoder gsw_encoder_checker #(.NUM_SLOT(NUM_SLOT)) chk_u (
    .core_clk, .reset, .red_active, .sim_mask, .param_busy, .dx_start,
    .dx_byte_ready, .dx_byte_valid, .dx_byte_first, .dx_byte, .dx_done,
    .dx_busy, .status_word, .fault_count);

/* File: sim/gsw_master_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// cyclic master: takes response bytes
// ----------------------------------------
module gsw_master_model (
    input wire core_clk,
    input wire reset,
    input wire slow,
    input wire dx_byte_valid,
    input wire dx_byte_first,
    input wire [7:0] dx_byte,
    output logic dx_byte_ready = 1'b0,
    output logic [15:0] rx_word = 16'h0000,
    output int rx_count = 0
);
    logic [7:0] hi_q = 8'h00;
    always @(posedge core_clk) begin
        if (!reset && dx_byte_valid && dx_byte_ready) begin
            if (dx_byte_first) begin
                hi_q <= dx_byte;
            end else begin
                rx_word <= {hi_q, dx_byte};
                rx_count <= rx_count + 1;
            end
        end
        // a slow master stalls at random
        dx_byte_ready <= #1 slow ? 1'($urandom % 2) : 1'b1;
    end
endmodule

/* File: sim/test_global_status_word_encoder.sv */
`timescale 1ns/1ns
`define chk(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
    fails++; $display("mismatch %s expected %h seen %h", n, e, a); end end
module test_global_status_word_encoder;
    localparam NS = 48;
    logic core_clk = 0, reset = 1, red_active = 0, param_busy = 0;
    logic dx_start = 0, slow = 0;
    logic [NS-1:0] sim_mask = 0, mod_fault = 0;
    logic [15:0] gen_err = 0, exp_q = 0, status_word, rx_word;
    logic [5:0] psu_fault = 0;
    logic [7:0] dx_byte;
    logic [6:0] fault_count;
    wire dx_byte_ready, dx_byte_valid, dx_byte_first, dx_done, dx_busy;
    int fails = 0, samples_checked = 0, xfers = 0, cnt_q, c, rx_count;
    bit prev_rst = 1;
    always #5 core_clk = ~core_clk;
    gsw_encoder #(.NUM_SLOT(NS)) dut_u (.core_clk, .reset, .red_active,
        .sim_mask, .param_busy, .gen_err, .mod_fault, .psu_fault,
        .dx_start, .dx_byte_ready, .dx_byte_valid, .dx_byte_first,
        .dx_byte, .dx_done, .dx_busy, .status_word, .fault_count);
    gsw_master_model mst_u (.core_clk, .reset, .slow, .dx_byte_valid,
        .dx_byte_first, .dx_byte, .dx_byte_ready, .rx_word, .rx_count);
    // lowest present code wins; unused general bits are ignored
    function automatic logic [15:0] exp_word(output int cnt);
        int g = 0, m = 0, p = 0, code = 0, slot = 0;
        logic [15:0] w;
        for (int i = 14; i > 0; i--)
            if (gen_err[i] && i != 6 && i != 7) begin g++; code = i; end
        for (int i = NS - 1; i > 0; i--)
            if (mod_fault[i]) begin m++; slot = i; end
        for (int i = 0; i < 6; i++) p += psu_fault[i];
        if (m > 0 && (code == 0 || code > 6)) code = 6;
        if (p > 0 && (code == 0 || code > 7)) code = 7;
        cnt = (g + m + p > 63) ? 63 : g + m + p;
        w = {red_active, |sim_mask, cnt != 0, code == 6, 4'(code), 1'b0,
            param_busy, 6'h00};
        if (cnt > 0 && g + m == 0) w[5:0] = psu_fault;
        else if (cnt > 1) w[7:0] = {1'b1, param_busy, 6'(cnt)};
        else if (m > 0) w[5:0] = 6'(slot);
        return w;
    endfunction
    always @(posedge core_clk) begin
        if (!prev_rst) begin
            `chk("status_word", exp_q, status_word)
            `chk("fault_count", 7'(cnt_q), fault_count)
        end
        exp_q = exp_word(c);
        cnt_q = c;
        prev_rst = reset;
    end
    task automatic set(logic [15:0] g, logic [NS-1:0] m, logic [5:0] p,
        logic [8:0] ctl);
        @(posedge core_clk);
        #1 gen_err = g;
        mod_fault = m;
        psu_fault = p;
        red_active = ctl[0];
        param_busy = ctl[1];
        sim_mask = {47'h0, ctl[2]} << ctl[8:3];
        @(posedge core_clk);
        #1;
    endtask
    task automatic xfer;
        logic [15:0] e;
        int k, n;
        e = exp_word(k);
        dx_start = 1'b1;
        @(posedge core_clk);
        #1 dx_start = 1'b0;
        n = 0;
        while (dx_done !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1 n++;
        end
        `chk("dx_done", 1'b1, dx_done)
        xfers++;
        `chk("rx_word", e, rx_word)
    endtask
    task end_of_test;
        `chk("rx_count", xfers, rx_count)
        $display("checked %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        logic [31:0] r;
        void'($urandom(32'ha4bf));
        repeat (12) @(posedge core_clk);
        #1 reset = 0;
        for (int k = 0; k < 32; k++) begin
            set(16'h1 << k[3:0], k[4] ? 48'h4 : 48'h0, 6'(k[4]), 9'h0);
            xfer();
        end
        set(16'h0300, 48'h0, 6'h03, 9'h001);
        `chk("example", 16'ha784, status_word)
        xfer();
        xfer();
        set(16'h0, 48'h10, 6'h0, 9'h1ff);
        set(16'h0, 48'h0, 6'h2a, 9'h002);
        set(16'hffff, {NS{1'b1}}, 6'h3f, 9'h1ff);
        for (int i = 0; i < 150; i++) begin
            r = $urandom;
            slow = r[0];
            set(r[1] ? 16'h1 << r[7:4] : 16'h0, r[2] ? 48'h1 << r[13:8]
                : 48'h0, r[3] ? r[21:16] : 6'h0, r[31:23]);
            if (r[22]) xfer();
        end
        end_of_test;
    end
    initial begin
        #500000;
        fails++;
        end_of_test;
    end
endmodule

/* File: src/gsw_byte_ser.v */
`timescale 1ns/1ns
`include "gsw_defs.vh"

// ----------------------------------------------------------------
// sends one frozen status word as high byte then low byte
// ----------------------------------------------------------------
module gsw_byte_ser (
    input wire core_clk,
    input wire reset,
    input wire start,
    input wire [15:0] word,
    input wire byte_ready,
    output wire byte_valid,
    output wire byte_first,
    output wire [7:0] byte_data,
    output wire done,
    output wire busy
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_HIGH = 3'b010;
    localparam [2:0] ST_LOW = 3'b100;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [7:0] byte_q;
    reg [7:0] byte_d;
    reg [7:0] low_q;
    reg [7:0] low_d;
    reg done_q;
    reg done_d;

    assign byte_valid = (state_q == ST_HIGH) | (state_q == ST_LOW);
    assign byte_first = (state_q == ST_HIGH);
    assign byte_data = byte_q;
    assign done = done_q;
    assign busy = (state_q != ST_IDLE);

    always @* begin
        state_d = state_q;
        byte_d = byte_q;
        low_d = low_q;
        done_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    byte_d = word[`GSW_BYTE_HI_MSB:`GSW_BYTE_HI_LSB];
                    low_d = word[`GSW_BYTE_LO_MSB:`GSW_BYTE_LO_LSB];
                    state_d = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (byte_ready) begin
                    byte_d = low_q;
                    state_d = ST_LOW;
                end
            end
            ST_LOW: begin
                if (byte_ready) begin
                    state_d = ST_IDLE;
                    done_d = 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            byte_q <= `GSW_RESET_BYTE;
            low_q <= `GSW_RESET_BYTE;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            byte_q <= byte_d;
            low_q <= low_d;
            done_q <= done_d;
        end
    end

endmodule

/* File: src/gsw_defs.vh */
`ifndef GSW_DEFS_VH
`define GSW_DEFS_VH

// ----------------------------------------------------------------
// status word bit positions
// ----------------------------------------------------------------
`define GSW_BIT_ACTIVE 15
`define GSW_BIT_SIM 14
`define GSW_BIT_FAULT 13
`define GSW_BIT_MODFLT 12
`define GSW_CODE_HI 11
`define GSW_CODE_LO 8
`define GSW_BIT_MULTI 7
`define GSW_BIT_PARAM 6
`define GSW_INFO_HI 5
`define GSW_INFO_LO 0
`define GSW_BYTE_HI_MSB 15
`define GSW_BYTE_HI_LSB 8
`define GSW_BYTE_LO_MSB 7
`define GSW_BYTE_LO_LSB 0

// ----------------------------------------------------------------
// error codes, lower value means higher priority
// ----------------------------------------------------------------
`define GSW_EC_NONE 4'h0
`define GSW_EC_IOC_RAM 4'h1
`define GSW_EC_IOC_REG 4'h2
`define GSW_EC_IOC_FLASH 4'h3
`define GSW_EC_IOC_INT 4'h4
`define GSW_EC_IOC_CMD 4'h5
`define GSW_EC_MODULE 4'h6
`define GSW_EC_PSU 4'h7
`define GSW_EC_MAIN_RAM 4'h8
`define GSW_EC_MAIN_FLASH 4'h9
`define GSW_EC_MAIN_WDOG 4'ha
`define GSW_EC_RED_ARITH 4'hb
`define GSW_EC_RED_NOPART 4'hc
`define GSW_EC_RED_LINK 4'hd
`define GSW_EC_RED_PARAM 4'he
`define GSW_EC_RSVD 4'hf

// general error inputs that are legal: codes 1..5 and 8..e
`define GSW_GEN_MASK 16'h7f3e

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define GSW_INFO_MAX 6'h3f
`define GSW_RESET_WORD 16'h0000
`define GSW_RESET_BYTE 8'h00
`define GSW_NUM_PSU 6
`define GSW_NUM_SLOT 48
`define GSW_COM_SLOT 6'h00
`define GSW_RESET_COUNT 7'h00
`define GSW_SCAN_W 64

`endif

/* File: src/gsw_encoder.v */
`timescale 1ns/1ns
`include "gsw_defs.vh"

module gsw_encoder #(
    parameter NUM_SLOT = `GSW_NUM_SLOT
) (
    input wire core_clk,
    input wire reset,
    input wire red_active,
    input wire [NUM_SLOT-1:0] sim_mask,
    input wire param_busy,
    input wire [15:0] gen_err,
    input wire [NUM_SLOT-1:0] mod_fault,
    input wire [`GSW_NUM_PSU-1:0] psu_fault,
    input wire dx_start,
    input wire dx_byte_ready,
    output wire dx_byte_valid,
    output wire dx_byte_first,
    output wire [7:0] dx_byte,
    output wire dx_done,
    output wire dx_busy,
    output wire [15:0] status_word,
    output wire [6:0] fault_count
);

    // ----------------------------------------------------------------
    // local sizes
    // ----------------------------------------------------------------
    // scan width of both helpers; NUM_SLOT must stay at or below it
    localparam SCAN_W = `GSW_SCAN_W;
    localparam PAD_MOD = SCAN_W - NUM_SLOT;
    localparam PAD_GEN = SCAN_W - 16;
    localparam PAD_PSU = SCAN_W - `GSW_NUM_PSU;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function [6:0] pop_count;
        input [SCAN_W-1:0] v;
        integer i;
        begin
            pop_count = 7'h00;
            for (i = 0; i < SCAN_W; i = i + 1) begin
                if (v[i]) begin
                    pop_count = pop_count + 7'h01;
                end
            end
        end
    endfunction

    // lowest set index wins; the loop runs downward so it is kept last
    function [6:0] first_set;
        input [SCAN_W-1:0] v;
        integer i;
        begin
            first_set = 7'h00;
            for (i = SCAN_W - 1; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    first_set = i[6:0];
                end
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // fault sources
    // ----------------------------------------------------------------
    wire [15:0] gen_valid;
    wire [NUM_SLOT-1:0] slot_mask;
    wire [NUM_SLOT-1:0] mod_valid;
    wire [SCAN_W-1:0] mod_wide;
    wire [SCAN_W-1:0] gen_wide;
    wire [SCAN_W-1:0] psu_wide;
    wire any_gen;
    wire any_mod;
    wire any_psu;
    wire psu_only;

    // codes 0, 6, 7 and f never come from the general inputs
    assign gen_valid = gen_err & `GSW_GEN_MASK;
    // slot 0 is this com unit and carries no module
    assign slot_mask = {{(NUM_SLOT-1){1'b1}}, 1'b0};
    assign mod_valid = mod_fault & slot_mask;
    assign mod_wide = {{PAD_MOD{1'b0}}, mod_valid};
    assign gen_wide = {{PAD_GEN{1'b0}}, gen_valid};
    assign psu_wide = {{PAD_PSU{1'b0}}, psu_fault};
    assign any_gen = |gen_valid;
    assign any_mod = |mod_valid;
    assign any_psu = |psu_fault;
    // supply faults alone keep their bitmap even when several are set
    assign psu_only = any_psu & ~any_gen & ~any_mod;

    // ----------------------------------------------------------------
    // error code and counts
    // ----------------------------------------------------------------
    reg [15:0] code_flags;
    reg [SCAN_W-1:0] code_wide;
    reg [6:0] code_idx;
    reg [3:0] code_sel;
    reg [7:0] total;
    reg [6:0] n_gen;
    reg [6:0] n_mod;
    reg [6:0] n_psu;
    reg [6:0] slot_sel;
    reg multi;

    always @* begin
        code_flags = gen_valid;
        // module and supply faults map to their own codes
        code_flags[`GSW_EC_MODULE] = any_mod;
        code_flags[`GSW_EC_PSU] = any_psu;
        code_flags[`GSW_EC_RSVD] = 1'b0;
        code_wide = {{PAD_GEN{1'b0}}, code_flags};
        code_idx = first_set(code_wide);
        code_sel = code_idx[3:0];
        n_gen = pop_count(gen_wide);
        n_mod = pop_count(mod_wide);
        n_psu = pop_count(psu_wide);
        // eight bits hold every source at once without wrapping
        total = {1'b0, n_gen} + {1'b0, n_mod} + {1'b0, n_psu};
        multi = (total > 8'h01);
        slot_sel = first_set(mod_wide);
    end

    // ----------------------------------------------------------------
    // status word assembly
    // ----------------------------------------------------------------
    reg [15:0] word_d;
    reg [5:0] info;
    reg [6:0] count_d;

    always @* begin
        info = 6'h00;
        count_d = (total > {2'b00, `GSW_INFO_MAX}) ?
            {1'b0, `GSW_INFO_MAX} : total[6:0];
        word_d = `GSW_RESET_WORD;
        word_d[`GSW_BIT_ACTIVE] = red_active;
        word_d[`GSW_BIT_SIM] = |sim_mask;
        word_d[`GSW_BIT_FAULT] = (total != 8'h00);
        word_d[`GSW_BIT_MODFLT] = (code_sel == `GSW_EC_MODULE);
        word_d[`GSW_CODE_HI:`GSW_CODE_LO] = code_sel;
        word_d[`GSW_BIT_PARAM] = param_busy;
        if (total == 8'h00) begin
            info = 6'h00;
        end else if (psu_only) begin
            info = psu_fault;
            word_d[`GSW_BIT_MULTI] = 1'b0;
        end else if (multi) begin
            // fault count, saturated at field size
            info = count_d[5:0];
            word_d[`GSW_BIT_MULTI] = 1'b1;
        end else if (any_mod) begin
            // slot of the one faulty module
            info = slot_sel[5:0];
            word_d[`GSW_BIT_MULTI] = 1'b0;
        end else begin
            // a general fault sits in this unit's own slot
            info = `GSW_COM_SLOT;
            word_d[`GSW_BIT_MULTI] = 1'b0;
        end
        word_d[`GSW_INFO_HI:`GSW_INFO_LO] = info;
    end

    // ----------------------------------------------------------------
    // status register
    // ----------------------------------------------------------------
    reg [15:0] word_q;
    // count sits beside the word so the field need not be decoded again
    reg [6:0] count_q;

    always @(posedge core_clk) begin
        if (reset) begin
            word_q <= `GSW_RESET_WORD;
            count_q <= `GSW_RESET_COUNT;
        end else begin
            word_q <= word_d;
            count_q <= count_d;
        end
    end

    assign status_word = word_q;
    assign fault_count = count_q;

    // ----------------------------------------------------------------
    // response head
    // ----------------------------------------------------------------
    // the word is frozen at frame start so both bytes belong to one
    // snapshot; a fault arriving mid-frame shows in the next frame
    // every response opens with the word
    gsw_byte_ser u_ser (
        .core_clk(core_clk),
        .reset(reset),
        .start(dx_start),
        .word(word_q),
        .byte_ready(dx_byte_ready),
        .byte_valid(dx_byte_valid),
        .byte_first(dx_byte_first),
        .byte_data(dx_byte),
        .done(dx_done),
        .busy(dx_busy)
    );

endmodule
